// ### mcud_defines.vh
// Purpose: Shared constants for the instruction decode and execute core
// Assumes: 13-bit instruction words, 8-bit data, 10-bit program counter
// Notes:   Port offsets, data path codes and the config reset value live here
// Operation
// (RULE1) Fetch and decode one 13-bit instruction word
// (RULE2) Single cycle; program counter writes take two
// (RULE3) Cycle option picks two or four clocks
// (RULE4) Timer tick is clock divided by two/four
// (RULE5) Branches, returns and true skips take two
// (RULE6) Any register bit set, cleared or tested
// (RULE7) I/O ports addressed like general registers
// (RULE8) Literals: 8-bit immediates, 10-bit branch targets
// (RULE9) Sleep and watchdog clear update status bits
// (RULE10) I/O control write and read via accumulator
// (RULE11) Interrupt enable, disable, return enabling interrupts
// (RULE12) Literal return loads accumulator, pops stack
// (RULE13) Call pushes return address; jump just loads
// (RULE14) Software trap pushes, jumps to address one
// (RULE15) Decrement, store, skip when zero, no flags
// (RULE16) Increment, store, skip when zero, no flags
// (RULE17) Rotate through carry, only carry changes
// (RULE18) Swap nibbles, flags unchanged
// (RULE19) Bit ops: three-bit index, six-bit register
// (RULE20) Software avoids bit set on interrupt flags
// (RULE21) Immediate subtract: literal minus accumulator, flags
// (RULE22) Immediate add into accumulator, updates flags
// (RULE23) Cycle option is configuration word bit ten
// (RULE24) Opcode bit six selects register destination
// (RULE25) Skipped instruction fetched, discarded, idle cycle
`ifndef MCUD_DEFINES_VH
`define MCUD_DEFINES_VH

// ==========================================================
// Register port map
`define MCUD_ADR_CFG        2'h0
`define MCUD_ADR_STATE      2'h1
`define MCUD_ADR_PC         2'h2
`define MCUD_CFG_RST        13'h0080
`define MCUD_CFG_CYC_BIT    10

// ==========================================================
// Core constants
`define MCUD_REG_PC         6'h02
`define MCUD_TRAP_VEC       10'h001
`define MCUD_TRAP_OP        13'h1e01
`define MCUD_PH_LAST_SHORT  2'h1
`define MCUD_PH_LAST_LONG   2'h3

// ==========================================================
// Data path operation codes
`define MCUD_OP_CLR         5'h00
`define MCUD_OP_DAA         5'h01
`define MCUD_OP_SUB         5'h02
`define MCUD_OP_DEC         5'h03
`define MCUD_OP_OR          5'h04
`define MCUD_OP_AND         5'h05
`define MCUD_OP_XOR         5'h06
`define MCUD_OP_ADD         5'h07
`define MCUD_OP_MOV         5'h08
`define MCUD_OP_COM         5'h09
`define MCUD_OP_INC         5'h0a
`define MCUD_OP_DECS        5'h0b
`define MCUD_OP_RRC         5'h0c
`define MCUD_OP_RLC         5'h0d
`define MCUD_OP_SWAP        5'h0e
`define MCUD_OP_INCS        5'h0f
`define MCUD_OP_BCLR        5'h10
`define MCUD_OP_BSET        5'h11

`endif

// ### mcud_alu.v
// Purpose: Eight-bit data path for the decode core
// Assumes: Carry set means no borrow on subtraction
// Notes:   Purely combinational; flags always computed, core masks them
`timescale 1ns/1ps
`include "mcud_defines.vh"

module mcud_alu (
    op,
    a,
    r,
    bsel,
    cin,
    dcin,
    res,
    z,
    c,
    dc
);
    input  wire [4:0] op;
    input  wire [7:0] a;
    input  wire [7:0] r;
    input  wire [2:0] bsel;
    input  wire       cin;
    input  wire       dcin;
    output reg  [7:0] res;
    output wire       z;
    output reg        c;
    output reg        dc;

    reg [8:0] wide;
    reg [4:0] nib;
    reg [7:0] mask;
    reg [7:0] adj;

    assign z = (res == 8'h00);

    always @* begin
        wide = 9'h000;
        nib  = 5'h00;
        mask = 8'h01 << bsel;
        adj  = 8'h00;
        res  = r;
        c    = cin;
        dc   = dcin;
        case (op)
            `MCUD_OP_CLR:  res = 8'h00;
            `MCUD_OP_DAA: begin
                adj = {((a[7:4] > 4'h9) || cin) ? 4'h6 : 4'h0,
                       ((a[3:0] > 4'h9) || dcin) ? 4'h6 : 4'h0};
                wide = {1'b0, a} + {1'b0, adj};
                res  = wide[7:0];
                c    = wide[8] | cin;
            end
            `MCUD_OP_SUB: begin
                wide = {1'b0, r} - {1'b0, a};
                nib  = {1'b0, r[3:0]} - {1'b0, a[3:0]};
                res  = wide[7:0];
                c    = ~wide[8];
                dc   = ~nib[4];
            end
            `MCUD_OP_ADD: begin
                wide = {1'b0, r} + {1'b0, a};
                nib  = {1'b0, r[3:0]} + {1'b0, a[3:0]};
                res  = wide[7:0];
                c    = wide[8];
                dc   = nib[4];
            end
            `MCUD_OP_DEC, `MCUD_OP_DECS: res = r - 8'h01;
            `MCUD_OP_INC, `MCUD_OP_INCS: res = r + 8'h01;
            `MCUD_OP_OR:   res = a | r;
            `MCUD_OP_AND:  res = a & r;
            `MCUD_OP_XOR:  res = a ^ r;
            `MCUD_OP_MOV:  res = r;
            `MCUD_OP_COM:  res = ~r;
            `MCUD_OP_RRC: begin
                res = {cin, r[7:1]};  // RULE17
                c   = r[0];
            end
            `MCUD_OP_RLC: begin
                res = {r[6:0], cin};  // RULE17
                c   = r[7];
            end
            `MCUD_OP_SWAP: res = {r[3:0], r[7:4]};  // RULE18
            `MCUD_OP_BCLR: res = r & ~mask;  // RULE6
            `MCUD_OP_BSET: res = r | mask;  // RULE6
            default:       res = r;
        endcase
    end
endmodule // mcud_alu

// ### mcud_core.v
// Purpose: Instruction decode and execute control of the small core
// Assumes: clk is the oscillator; program memory and register file
//          answer combinationally in the same clock domain
// Notes:   One instruction executes on the last clock of each cycle
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "mcud_defines.vh"

module mcud_core #(
    parameter STACK_DEPTH = 5
) (
    clk,
    rst_b,
    bus_addr,
    bus_wdata,
    bus_wr,
    bus_rd,
    bus_rdata,
    pm_addr,
    pm_data,
    rf_addr,
    rf_rdata,
    rf_we,
    rf_waddr,
    rf_wdata,
    io_we,
    io_addr,
    io_wdata,
    io_rdata,
    opt_ctl,
    wake,
    acc,
    flag_z,
    flag_c,
    flag_dc,
    flag_to,
    flag_pd,
    irq_en,
    wdt_clr,
    halted,
    tmr_tick
);
    input  wire        clk;
    input  wire        rst_b;
    input  wire [1:0]  bus_addr;
    input  wire [15:0] bus_wdata;
    input  wire        bus_wr;
    input  wire        bus_rd;
    output reg  [15:0] bus_rdata;
    output wire [9:0]  pm_addr;
    input  wire [12:0] pm_data;
    output wire [5:0]  rf_addr;
    input  wire [7:0]  rf_rdata;
    output reg         rf_we;
    output reg  [5:0]  rf_waddr;
    output reg  [7:0]  rf_wdata;
    output reg         io_we;
    output reg  [3:0]  io_addr;
    output reg  [7:0]  io_wdata;
    input  wire [7:0]  io_rdata;
    output wire [7:0]  opt_ctl;
    input  wire        wake;
    output wire [7:0]  acc;
    output wire        flag_z;
    output wire        flag_c;
    output wire        flag_dc;
    output wire        flag_to;
    output wire        flag_pd;
    output wire        irq_en;
    output reg         wdt_clr;
    output wire        halted;
    output reg         tmr_tick;

    // ==========================================================
    // State
    reg [12:0] cfg_q;
    reg [1:0]  ph_q;
    reg [9:0]  pc_q;
    reg [7:0]  acc_q;
    reg [7:0]  opt_q;
    reg        z_q, c_q, dc_q, to_q, pd_q, ie_q;
    reg        halt_q, idle_q, skp_q;
    reg        wk1_q, wk2_q;
    reg [9:0]  stk_q [0:STACK_DEPTH-1];

    // I/O control registers accept only a limited address set
    function io_ok;
        input [3:0] a;
        begin
            io_ok = (a == 4'h5) || (a == 4'h6) || (a >= 4'hb);
        end
    endfunction

    // ==========================================================
    // Cycle timing
    wire       cyc_long = cfg_q[`MCUD_CFG_CYC_BIT];  // RULE23
    wire [1:0] ph_last  = cyc_long ? `MCUD_PH_LAST_LONG
                                   : `MCUD_PH_LAST_SHORT;  // RULE3
    wire       ph_end   = (ph_q == ph_last);
    wire       exe      = ph_end && !halt_q;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ph_q     <= 2'h0;
            tmr_tick <= 1'b0;
        end else begin
            ph_q     <= ph_end ? 2'h0 : ph_q + 2'h1;  // RULE3
            tmr_tick <= ph_end;  // RULE4
        end
    end

    // ==========================================================
    // Decode
    wire [12:0] ins   = pm_data;  // RULE1
    wire [2:0]  bidx  = ins[8:6];  // RULE19
    wire [7:0]  k8    = ins[7:0];  // RULE8
    wire [9:0]  k10   = ins[9:0];  // RULE8
    wire [9:0]  pc_inc = pc_q + 10'h001;
    // Reading the program counter register returns the live counter
    wire [7:0]  rd    = (rf_addr == `MCUD_REG_PC) ? pc_q[7:0] : rf_rdata;
    wire        bitv  = rd[bidx];

    assign rf_addr = ins[5:0];  // RULE7

    reg  [4:0] op;
    reg        use_k, wr_a, wr_r, fz, fc, fdc;
    reg        br, push, pop, skp_bit, skp_z;
    reg        ie_on, ie_off, wdc, slp, write_io_ctl, read_io_ctl, ow, orr;
    reg  [9:0] br_pc;
    wire [7:0] alu_res;
    wire       alu_z, alu_c, alu_dc;

    always @* begin
        op = `MCUD_OP_MOV;
        use_k = 1'b0;
        wr_a = 1'b0;
        wr_r = 1'b0;
        fz = 1'b0;
        fc = 1'b0;
        fdc = 1'b0;
        br = 1'b0;
        br_pc = k10;
        push = 1'b0;
        pop = 1'b0;
        skp_bit = 1'b0;
        skp_z = 1'b0;
        ie_on = 1'b0;
        ie_off = 1'b0;
        wdc = 1'b0;
        slp = 1'b0;
        write_io_ctl = 1'b0;
        read_io_ctl = 1'b0;
        ow = 1'b0;
        orr = 1'b0;
        if (!ins[12]) begin
            if (ins[11]) begin
                case (ins[10:9])
                    2'b00: begin
                        op = `MCUD_OP_BCLR;  // RULE19
                        wr_r = 1'b1;
                    end
                    2'b01: begin
                        op = `MCUD_OP_BSET;  // RULE19
                        wr_r = 1'b1;
                    end
                    2'b10: skp_bit = ~bitv;  // RULE19
                    default: skp_bit = bitv;  // RULE19
                endcase
            end else if (ins[10:8] != 3'h0) begin
                op   = {1'b0, ins[10:7]};
                wr_a = ~ins[6];  // RULE24
                wr_r = ins[6];  // RULE24
                case (op)
                    `MCUD_OP_SUB, `MCUD_OP_ADD: begin
                        fz = 1'b1;
                        fc = 1'b1;
                        fdc = 1'b1;
                    end
                    `MCUD_OP_DECS: skp_z = 1'b1;  // RULE15
                    `MCUD_OP_INCS: skp_z = 1'b1;  // RULE16
                    `MCUD_OP_RRC, `MCUD_OP_RLC: fc = 1'b1;  // RULE17
                    `MCUD_OP_SWAP: fz = 1'b0;  // RULE18
                    default: fz = 1'b1;
                endcase
            end else begin
                case (ins[7:6])
                    2'b00: begin
                        if (!ins[4]) begin
                            case (ins[3:0])
                                4'h0: ;
                                4'h1: begin
                                    op = `MCUD_OP_DAA;
                                    wr_a = 1'b1;
                                    fc = 1'b1;
                                end
                                4'h2: ow = 1'b1;
                                4'h3: begin
                                    wdc = 1'b1;  // RULE9
                                    slp = 1'b1;  // RULE9
                                end
                                4'h4: wdc = 1'b1;  // RULE9
                                default: write_io_ctl = io_ok(ins[3:0]);  // RULE10
                            endcase
                        end else begin
                            case (ins[3:0])
                                4'h0: ie_on = 1'b1;  // RULE11
                                4'h1: ie_off = 1'b1;  // RULE11
                                4'h2: begin
                                    pop = 1'b1;  // RULE5
                                    br = 1'b1;
                                end
                                4'h3: begin
                                    pop = 1'b1;  // RULE11
                                    br = 1'b1;
                                    ie_on = 1'b1;
                                end
                                4'h4: orr = 1'b1;
                                default: read_io_ctl = io_ok(ins[3:0]);  // RULE10
                            endcase
                        end
                    end
                    2'b01: wr_r = 1'b1;
                    default: begin
                        op = `MCUD_OP_CLR;
                        wr_a = ~ins[8] & ~ins[6];
                        wr_r = ins[6];
                        fz = 1'b1;
                    end
                endcase
            end
        end else if (!ins[11]) begin
            br   = 1'b1;  // RULE13
            push = ~ins[10];  // RULE13
        end else begin
            use_k = 1'b1;
            wr_a  = 1'b1;
            case (ins[10:8])
                3'h0: op = `MCUD_OP_MOV;
                3'h1: begin
                    op = `MCUD_OP_OR;
                    fz = 1'b1;
                end
                3'h2: begin
                    op = `MCUD_OP_AND;
                    fz = 1'b1;
                end
                3'h3: begin
                    op = `MCUD_OP_XOR;
                    fz = 1'b1;
                end
                3'h4: begin
                    op = `MCUD_OP_MOV;  // RULE12
                    pop = 1'b1;
                    br = 1'b1;
                end
                3'h5: begin
                    op = `MCUD_OP_SUB;  // RULE21
                    fz = 1'b1;
                    fc = 1'b1;
                    fdc = 1'b1;
                end
                3'h6: begin
                    wr_a  = 1'b0;
                    br    = (ins == `MCUD_TRAP_OP);  // RULE14
                    push  = br;
                    br_pc = `MCUD_TRAP_VEC;
                end
                default: begin
                    op = `MCUD_OP_ADD;  // RULE22
                    fz = 1'b1;
                    fc = 1'b1;
                    fdc = 1'b1;
                end
            endcase
        end
        if (pop)
            br_pc = stk_q[0];
    end

    mcud_alu u_alu (
        .op   (op),
        .a    (acc_q),
        .r    (use_k ? k8 : (ins[12:6] == 7'h01) ? acc_q : rd),
        .bsel (bidx),
        .cin  (c_q),
        .dcin (dc_q),
        .res  (alu_res),
        .z    (alu_z),
        .c    (alu_c),
        .dc   (alu_dc)
    );

    // A store into the counter register redirects the flow
    wire pc_wr = wr_r && (rf_addr == `MCUD_REG_PC);  // RULE2
    wire skip  = skp_bit | (skp_z & alu_z);  // RULE15 RULE16
    wire act   = exe && !idle_q;

    // ==========================================================
    // Execute
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pc_q    <= 10'h000;
            acc_q   <= 8'h00;
            opt_q   <= 8'h00;
            z_q     <= 1'b0;
            c_q     <= 1'b0;
            dc_q    <= 1'b0;
            to_q    <= 1'b1;
            pd_q    <= 1'b1;
            ie_q    <= 1'b0;
            idle_q  <= 1'b0;
            skp_q   <= 1'b0;
            rf_we   <= 1'b0;
            rf_waddr <= 6'h00;
            rf_wdata <= 8'h00;
            io_we   <= 1'b0;
            io_addr <= 4'h0;
            io_wdata <= 8'h00;
            wdt_clr <= 1'b0;
        end else begin
            rf_we   <= 1'b0;
            io_we   <= 1'b0;
            wdt_clr <= 1'b0;
            if (exe && idle_q) begin
                // Bubble: a skipped word is fetched and thrown away
                idle_q <= 1'b0;  // RULE25
                skp_q  <= 1'b0;
                if (skp_q)
                    pc_q <= pc_inc;  // RULE25
            end else if (act) begin
                pc_q <= pc_inc;
                if (br) begin
                    pc_q   <= br_pc;  // RULE13
                    idle_q <= 1'b1;  // RULE5
                end else if (pc_wr) begin
                    pc_q   <= {pc_q[9:8], alu_res};
                    idle_q <= 1'b1;  // RULE2
                end else if (skip) begin
                    idle_q <= 1'b1;  // RULE5
                    skp_q  <= 1'b1;
                end
                if (wr_a)
                    acc_q <= alu_res;
                if (read_io_ctl)
                    acc_q <= io_rdata;  // RULE10
                if (orr)
                    acc_q <= opt_q;
                if (ow)
                    opt_q <= acc_q;
                if (wr_r && !pc_wr) begin
                    rf_we    <= 1'b1;
                    rf_waddr <= rf_addr;
                    rf_wdata <= alu_res;
                end
                if (write_io_ctl) begin
                    io_we    <= 1'b1;  // RULE10
                    io_addr  <= ins[3:0];
                    io_wdata <= acc_q;
                end
                if (fz)
                    z_q <= alu_z;
                if (fc)
                    c_q <= alu_c;
                if (fdc)
                    dc_q <= alu_dc;
                if (ie_on)
                    ie_q <= 1'b1;  // RULE11
                if (ie_off)
                    ie_q <= 1'b0;  // RULE11
                if (wdc) begin
                    wdt_clr <= 1'b1;  // RULE9
                    to_q    <= 1'b1;
                    pd_q    <= ~slp;  // RULE9
                end
            end
        end
    end

    // ==========================================================
    // Return stack; overflow silently drops the oldest entry
    genvar gi;
    generate
        for (gi = 0; gi < STACK_DEPTH; gi = gi + 1) begin : g_stk
            always @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    stk_q[gi] <= 10'h000;
                end else if (act && push) begin
                    if (gi == 0)
                        stk_q[gi] <= pc_inc;  // RULE13 RULE14
                    else
                        stk_q[gi] <= stk_q[(gi == 0) ? 0 : gi - 1];
                end else if (act && pop) begin
                    if (gi == STACK_DEPTH - 1)
                        stk_q[gi] <= 10'h000;
                    else
                        stk_q[gi] <= stk_q[(gi == STACK_DEPTH - 1) ? gi : gi + 1];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Sleep; the wake pin is asynchronous so it is synchronised first
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wk1_q  <= 1'b0;
            wk2_q  <= 1'b0;
            halt_q <= 1'b0;
        end else begin
            wk1_q <= wake;
            wk2_q <= wk1_q;
            if (act && slp)
                halt_q <= 1'b1;  // RULE9
            else if (wk2_q)
                halt_q <= 1'b0;
        end
    end

    // ==========================================================
    // Register port
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q     <= `MCUD_CFG_RST;
            bus_rdata <= 16'h0000;
        end else begin
            if (bus_wr && bus_addr == `MCUD_ADR_CFG)
                cfg_q <= bus_wdata[12:0];
            bus_rdata <= 16'h0000;
            if (bus_rd) begin
                case (bus_addr)
                    `MCUD_ADR_CFG:   bus_rdata <= {3'h0, cfg_q};
                    `MCUD_ADR_STATE: bus_rdata <= {acc_q, 1'b0, halt_q, to_q, pd_q,
                                                   ie_q, z_q, dc_q, c_q};
                    `MCUD_ADR_PC:    bus_rdata <= {6'h00, pc_q};
                    default:         bus_rdata <= 16'h0000;
                endcase
            end
        end
    end

    assign pm_addr = pc_q;
    assign opt_ctl = opt_q;
    assign acc     = acc_q;
    assign flag_z  = z_q;
    assign flag_c  = c_q;
    assign flag_dc = dc_q;
    assign flag_to = to_q;
    assign flag_pd = pd_q;
    assign irq_en  = ie_q;
    assign halted  = halt_q;
endmodule // mcud_core

// ### mcud_core_chk_sva.sv
// Purpose: Port assertions for mcud_core
// Assumes: One clock, rst_b asynchronous active low
// Notes:   Cycle length is tracked from config writes on the bus
`timescale 1ns/1ps
module mcud_core_chk (
    input wire        clk,
    input wire        rst_b,
    input wire [1:0]  bus_addr,
    input wire [15:0] bus_wdata,
    input wire        bus_wr,
    input wire        bus_rd,
    input wire [15:0] bus_rdata,
    input wire [9:0]  pm_addr,
    input wire [7:0]  acc,
    input wire        rf_we,
    input wire        flag_to,
    input wire        irq_en,
    input wire        wdt_clr,
    input wire        halted,
    input wire        tmr_tick
);
    // ==========================================================
    // Mode tracking; ticks just after a mode change are not judged
    reg       long_q;
    reg [1:0] settle_q;
    wire      judge;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            long_q   <= 1'b0;
            settle_q <= 2'h0;
        end else if (bus_wr && bus_addr == 2'h0) begin
            long_q   <= bus_wdata[10];
            settle_q <= 2'h0;
        end else if (tmr_tick && settle_q != 2'h3) begin
            settle_q <= settle_q + 2'h1;
        end
    end
    assign judge = (settle_q == 2'h3) && !halted;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // Checks
    a_tick_short_len: assert property (tmr_tick && judge && !long_q |=> !tmr_tick ##1 tmr_tick)
        else $error("short cycle tick spacing wrong");
    a_tick_long_len: assert property (tmr_tick && judge && long_q |=> !tmr_tick [*3] ##1 tmr_tick)
        else $error("long cycle tick spacing wrong");
    a_acc_on_tick: assert property ($changed(acc) |-> tmr_tick)
        else $error("accumulator changed outside execute");
    a_irq_on_tick: assert property ($changed(irq_en) |-> tmr_tick)
        else $error("interrupt enable changed outside execute");
    a_wdt_pulse: assert property (wdt_clr |-> flag_to ##1 !wdt_clr)
        else $error("watchdog clear pulse wrong");
    a_rf_we_pulse: assert property (rf_we |=> !rf_we)
        else $error("register write pulse too long");
    a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 16'h0)
        else $error("read data outside answer cycle");
    a_unmapped_zero: assert property (bus_rd && bus_addr == 2'h3 |=> bus_rdata == 16'h0)
        else $error("unmapped read not zero");
    a_pc_read: assert property (bus_rd && bus_addr == 2'h2
        |=> bus_rdata == {6'h0, $past(pm_addr)})
        else $error("program counter read wrong");
endmodule // mcud_core_chk

// ### tb_top.sv
// Purpose: Self-checking bench for mcud_core
// Assumes: Bench plays program memory and register file
// Notes:   One program is run in both cycle lengths
`timescale 1ns/1ps
module tb_top;
    // ==========================================================
    // Signals and models
    reg         clk, rst_b, bus_wr, bus_rd, go, on, done;
    reg  [1:0]  bus_addr;
    reg  [15:0] bus_wdata, d;
    wire [15:0] bus_rdata;
    wire [9:0]  pm_addr;
    wire [5:0]  rf_addr, rf_waddr;
    wire [7:0]  rf_wdata, opt_ctl, acc;
    wire        rf_we, flag_z, flag_c, flag_dc, flag_to, irq_en, wdt_clr, halted, tmr_tick;
    reg  [12:0] mem [0:1023];
    reg  [7:0]  rf [0:63];
    integer     bad_count, samples_checked, ticks, clks, n;
    // Program from 0x20; address 0 parks until go, address 1 is the trap vector
    localparam [271:0] PROG = {16'h1805, 16'h1f03, 16'h1d0a, 16'h0050, 16'h0011, 16'h05d1,
        16'h1800, 16'h103c, 16'h1e01, 16'h0002, 16'h0004, 16'h06d2, 16'h0752, 16'h0ad3,
        16'h0ed3, 16'h1800, 16'h0042};
    wire [12:0] pm_data = (pm_addr == 10'h0) ? (go ? 13'h1420 : 13'h1400) : mem[pm_addr];
    always @(posedge clk) if (rf_we) rf[rf_waddr] <= rf_wdata;
    always @(posedge clk) begin
        if (on) begin
            clks  <= clks + 1;
            ticks <= ticks + tmr_tick;
            if (pm_addr == 10'h077) begin
                on   <= 1'b0;
                done <= 1'b1;
            end
        end else if (go && !done && pm_addr == 10'h020) on <= 1'b1;
    end
    mcud_core i_mcud_core (.clk(clk), .rst_b(rst_b), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .pm_addr(pm_addr), .pm_data(pm_data), .rf_addr(rf_addr), .rf_rdata(rf[rf_addr]),
        .rf_we(rf_we), .rf_waddr(rf_waddr), .rf_wdata(rf_wdata), .io_we(), .io_addr(),
        .io_wdata(), .io_rdata(8'h00), .opt_ctl(opt_ctl), .wake(1'b0), .acc(acc),
        .flag_z(flag_z), .flag_c(flag_c), .flag_dc(flag_dc), .flag_to(flag_to),
        .flag_pd(), .irq_en(irq_en), .wdt_clr(wdt_clr), .halted(halted),
        .tmr_tick(tmr_tick));
    // ==========================================================
    // Tasks
    task chk(input [15:0] got, input [15:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task bwr(input [1:0] a, input [15:0] v);
        begin
            bus_addr  <= a;
            bus_wdata <= v;
            bus_wr    <= 1'b1;
            @(posedge clk);
            bus_wr    <= 1'b0;
            @(posedge clk);
        end
    endtask
    // Read data stand only in the cycle after the strobe
    task brd(input [1:0] a);
        begin
            bus_addr <= a;
            bus_rd   <= 1'b1;
            @(posedge clk);
            bus_rd   <= 1'b0;
            @(negedge clk);
            d = bus_rdata;
            @(posedge clk);
        end
    endtask
    task end_of_test;
        begin
            $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
            if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task run(input [15:0] cfg, input integer per);
        begin
            rst_b <= 1'b0;
            go    <= 1'b0;
            on    <= 1'b0;
            done  <= 1'b0;
            ticks <= 0;
            clks  <= 0;
            rf[17] = 8'h01;
            rf[18] = 8'h81;
            rf[19] = 8'h00;
            repeat (6) @(posedge clk);
            rst_b <= 1'b1;
            @(posedge clk);
            brd(2'h0);
            chk(d, 16'h0080);
            bwr(2'h0, cfg);
            bwr(2'h1, 16'hffff);
            repeat (16) @(posedge clk);
            go <= 1'b1;
            n = 0;
            while (!done && n < 2000) begin
                @(posedge clk);
                n = n + 1;
            end
            if (!done) begin
                bad_count = bad_count + 1;
                end_of_test;
            end
            chk(ticks[15:0], 16'd24);
            chk(clks[15:0], 16'd24 * per[15:0]);
            chk({opt_ctl, 5'h0, flag_z, flag_dc, flag_c}, 16'h7703);
            chk({8'h0, rf[16]}, 16'h0002);
            chk({8'h0, rf[17]}, 16'h0000);
            chk({8'h0, rf[18]}, 16'h0030);
            chk({8'h0, rf[19]}, 16'h0008);
            brd(2'h1);
            chk(d, 16'h773b);
            brd(2'h2);
            chk(d, 16'h0077);
            brd(2'h3);
            chk(d, 16'h0000);
        end
    endtask
    // ==========================================================
    // Clock and sequence
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        rst_b = 1'b0;
        {bus_wr, bus_rd, go, on, done} = 5'h0;
        bus_addr  = 2'h0;
        bus_wdata = 16'h0;
        bad_count = 0;
        samples_checked = 0;
        for (n = 0; n < 1024; n = n + 1) mem[n] = 13'h0;
        for (n = 0; n < 17; n = n + 1) mem[32 + n] = PROG[(16 - n) * 16 +: 13];
        mem[1] = 13'h0013;
        mem[60] = 13'h1c77;
        mem[119] = 13'h1477;
        run(16'h0080, 2);
        run(16'h0480, 4);
        end_of_test;
    end
endmodule // tb_top
bind mcud_core mcud_core_chk i_mcud_core_chk (.clk(clk), .rst_b(rst_b), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .pm_addr(pm_addr), .acc(acc), .rf_we(rf_we), .flag_to(flag_to), .irq_en(irq_en),
    .wdt_clr(wdt_clr), .halted(halted), .tmr_tick(tmr_tick));
